// ---- hdl/sble_defs.svh ----
// Opcode patterns, field positions and reset values for the skip/branch executor.
// Assumes 14-bit instruction words and an 8-bit data path.
`ifndef SBLE_DEFS_SVH
`define SBLE_DEFS_SVH

`define SBLE_OP_DEC_SKIP   6'h0b
`define SBLE_OP_INC_SKIP   6'h0f
`define SBLE_OP_BRANCH     3'h5
`define SBLE_OP_LIT_OR     6'h38
`define SBLE_DEST_BIT      7
`define SBLE_LATCH_LO      3
`define SBLE_LATCH_HI      4
`define SBLE_PC_RESET      13'h0000
`define SBLE_W_RESET       8'h00

`endif

// ---- hdl/sble_exec.sv ----
// Executes decrement-skip, increment-skip, unconditional branch and literal-OR.
// Assumes program memory presents one word with INSTR_VALID and a file register
// file that returns FILE_RDATA in the same cycle that FILE_ADDR changes.
//
// What this block does
// RL1: Decrement-skip subtracts one from file register; destination bit picks W or file.
// RL2: Zero decrement result turns the following instruction into a no-operation.
// RL3: Increment-skip adds one to file register; destination bit picks W or file.
// RL4: Zero increment result turns the following instruction into a no-operation.
// RL5: Branch loads its eleven-bit immediate into program counter bits ten to zero.
// RL6: Branch copies high latch bits four and three into counter bits twelve, eleven.
// RL7: Literal-OR ORs W with eight-bit literal, result into W, updates zero flag.
// RL8: Zero flag set when literal-OR result is zero, cleared otherwise.
`timescale 1ns/1ns
`include "sble_defs.svh"

module sble_exec (
   input  wire logic        CLOCK,
   input  wire logic        RST_N,
   input  wire logic        INSTR_VALID,
   input  wire logic [13:0] INSTR,
   input  wire logic [7:0]  FILE_RDATA,
   input  wire logic [7:0]  PC_HIGH_LATCH,
   output logic             INSTR_READY,
   output logic [6:0]       FILE_ADDR,
   output logic             FILE_WE,
   output logic [7:0]       FILE_WDATA,
   output logic [7:0]       W_REG,
   output logic             Z_FLAG,
   output logic [12:0]      PC,
   output logic             SKIPPED
);

   logic                 rst_meta_q;
   logic                 rst_sync_n_q;
   sble_pkg::sble_regs_s r_q;
   sble_pkg::sble_regs_s r_d;
   logic [7:0]           result;
   logic [7:0]           or_res;
   logic                 take;
   logic                 res_zero;
   logic [12:0]          pc_inc;
   logic [12:0]          br_pc;

   // Opcode and field decoding
   function automatic logic is_dec(input logic [13:0] word);
      begin
         is_dec = word[13:8] == `SBLE_OP_DEC_SKIP;
      end
   endfunction

   function automatic logic is_inc(input logic [13:0] word);
      begin
         is_inc = word[13:8] == `SBLE_OP_INC_SKIP;
      end
   endfunction

   function automatic logic is_skip(input logic [13:0] word);
      begin
         is_skip = is_dec(word) || is_inc(word);
      end
   endfunction

   function automatic logic is_branch(input logic [13:0] word);
      begin
         is_branch = word[13:11] == `SBLE_OP_BRANCH;
      end
   endfunction

   function automatic logic is_lit_or(input logic [13:0] word);
      begin
         is_lit_or = word[13:8] == `SBLE_OP_LIT_OR;
      end
   endfunction

   function automatic logic dest_bit(input logic [13:0] word);
      begin
         dest_bit = word[`SBLE_DEST_BIT];
      end
   endfunction

   function automatic logic [6:0] file_field(input logic [13:0] word);
      begin
         file_field = word[6:0];
      end
   endfunction

   function automatic logic [7:0] lit8(input logic [13:0] word);
      begin
         lit8 = word[7:0];
      end
   endfunction

   function automatic logic [10:0] lit11(input logic [13:0] word);
      begin
         lit11 = word[10:0];
      end
   endfunction

   function automatic logic is_zero(input logic [7:0] v);
      begin
         is_zero = v == 8'h00;
      end
   endfunction

   function automatic logic [12:0] bump_pc(input logic [12:0] pc_now);
      begin
         bump_pc = pc_now + 13'h0001;
      end
   endfunction

   // Wraps at both ends; the increment-skip test expects ff to wrap to 00
   function automatic logic [7:0] step_value(input logic up, input logic [7:0] v);
      begin
         if (up) begin
            step_value = v + 8'h01;
         end else begin
            step_value = v - 8'h01;
         end
      end
   endfunction

   function automatic logic [12:0] branch_target(input logic [7:0]  latch,
                                                 input logic [13:0] word);
      logic [1:0]  page;
      logic [10:0] low;
      begin
         page          = latch[`SBLE_LATCH_HI:`SBLE_LATCH_LO];
         low           = lit11(word);
         branch_target = {page, low};
      end
   endfunction

   // Reset release through two flops
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_q   <= 1'b0;
         rst_sync_n_q <= 1'b0;
      end else begin
         rst_meta_q   <= 1'b1;
         rst_sync_n_q <= rst_meta_q;
      end
   end

   always_comb begin
      r_d         = r_q;
      r_d.file_we = 1'b0;
      r_d.skipped = 1'b0;
      // Operands and arithmetic for this cycle
      take        = INSTR_VALID && r_q.ready;
      result      = step_value(r_q.inc, FILE_RDATA);                  // [RL1] [RL3]
      res_zero    = is_zero(result);
      or_res      = r_q.w | lit8(INSTR);
      pc_inc      = bump_pc(r_q.pc);
      br_pc       = branch_target(PC_HIGH_LATCH, INSTR);

      unique case (r_q.st)
         sble_pkg::ST_IDLE: begin
            if (take) begin
               r_d.pc = pc_inc;
               if (r_q.squash) begin
                  // Slot replaced by a no-operation
                  r_d.squash  = 1'b0;
                  r_d.skipped = 1'b1;                                   // [RL2] [RL4] [RL5]
               end else if (is_skip(INSTR)) begin
                  r_d.st    = sble_pkg::ST_READ;
                  r_d.ready = 1'b0;
                  r_d.addr  = file_field(INSTR);
                  r_d.dest  = dest_bit(INSTR);
                  r_d.inc   = is_inc(INSTR);
               end else if (is_branch(INSTR)) begin
                  r_d.pc     = br_pc;                                   // [RL5] [RL6]
                  r_d.squash = 1'b1;                                    // [RL5]
               end else if (is_lit_or(INSTR)) begin
                  r_d.w = or_res;                                       // [RL7]
                  r_d.z = is_zero(or_res);                              // [RL8]
               end
            end
         end
         sble_pkg::ST_READ: begin
            // File data arrives in the same cycle as the registered address
            r_d.st    = sble_pkg::ST_IDLE;
            r_d.ready = 1'b1;
            if (r_q.dest) begin
               r_d.file_we = 1'b1;                                      // [RL1] [RL3]
               r_d.wdata   = result;
            end else begin
               r_d.w = result;                                          // [RL1] [RL3]
            end
            r_d.squash = res_zero;                                      // [RL2] [RL4]
         end
         default: begin
            // Illegal state code, back to idle
            r_d.st    = sble_pkg::ST_IDLE;
            r_d.ready = 1'b1;
         end
      endcase
   end

   // Register update
   always_ff @(posedge CLOCK or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         r_q.st      <= sble_pkg::ST_IDLE;
         r_q.ready   <= 1'b1;
         r_q.addr    <= 7'h00;
         r_q.dest    <= 1'b0;
         r_q.inc     <= 1'b0;
         r_q.file_we <= 1'b0;
         r_q.wdata   <= 8'h00;
         r_q.w       <= `SBLE_W_RESET;
         r_q.z       <= 1'b0;
         r_q.pc      <= `SBLE_PC_RESET;
         r_q.squash  <= 1'b0;
         r_q.skipped <= 1'b0;
      end else begin
         r_q <= r_d;
      end
   end

   // Outputs straight from the state flops
   assign INSTR_READY = r_q.ready;
   assign FILE_ADDR   = r_q.addr;
   assign FILE_WE     = r_q.file_we;
   assign FILE_WDATA  = r_q.wdata;
   assign W_REG       = r_q.w;
   assign Z_FLAG      = r_q.z;
   assign PC          = r_q.pc;
   assign SKIPPED     = r_q.skipped;

endmodule

// ---- hdl/sble_pkg.sv ----
// Types for the skip/branch executor.
// Assumes sble_defs.svh is compiled alongside.
package sble_pkg;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_READ = 2'b10
   } sble_state_e;

   typedef struct packed {
      sble_state_e st;
      logic        ready;
      logic [6:0]  addr;
      logic        dest;
      logic        inc;
      logic        file_we;
      logic [7:0]  wdata;
      logic [7:0]  w;
      logic        z;
      logic [12:0] pc;
      logic        squash;
      logic        skipped;
   } sble_regs_s;

endpackage

// ---- verification/sble_exec_checker.sv ----
// Port checker for sble_exec, bound at the foot.
// Assumes the defs header is on the include path.
`timescale 1ns/1ns
`include "sble_defs.svh"
module sble_chk (
   input wire logic        CLOCK,
   input wire logic        RST_N,
   input wire logic        INSTR_VALID,
   input wire logic [13:0] INSTR,
   input wire logic [7:0]  FILE_RDATA,
   input wire logic [7:0]  PC_HIGH_LATCH,
   input wire logic        INSTR_READY,
   input wire logic        FILE_WE,
   input wire logic [7:0]  FILE_WDATA,
   input wire logic [7:0]  W_REG,
   input wire logic        Z_FLAG,
   input wire logic [12:0] PC,
   input wire logic        SKIPPED
);
   logic slot_q;
   logic skp_q;
   logic inc_q;
   wire  tk = INSTR_VALID && INSTR_READY;
   wire  lv = tk && !slot_q;
   wire  dc = lv && INSTR[13:8] == `SBLE_OP_DEC_SKIP;
   wire  ic = lv && INSTR[13:8] == `SBLE_OP_INC_SKIP;
   wire  lo = lv && INSTR[13:8] == `SBLE_OP_LIT_OR;
   wire  br = lv && INSTR[13:11] == `SBLE_OP_BRANCH;
   // Mirror of the pending no-operation slot
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         slot_q <= 1'b0;
         skp_q  <= 1'b0;
         inc_q  <= 1'b0;
      end else begin
         skp_q <= dc || ic;
         inc_q <= ic;
         if (skp_q) begin
            slot_q <= (inc_q ? FILE_RDATA + 8'h01 : FILE_RDATA - 8'h01) == 8'h00;
         end else if (tk) begin
            slot_q <= br;
         end
      end
   end
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   dec_write_a: assert property (dc && INSTR[7] |=> ##1 FILE_WE &&
      FILE_WDATA == $past(FILE_RDATA) - 8'h01) else $error("dec write");
   dec_skip_a: assert property (dc ##2 tk |=>
      SKIPPED == ($past(FILE_RDATA, 2) == 8'h01)) else $error("dec skip");
   inc_to_w_a: assert property (ic && !INSTR[7] |=> ##1
      W_REG == $past(FILE_RDATA) + 8'h01) else $error("inc result");
   inc_skip_a: assert property (ic ##2 tk |=>
      SKIPPED == ($past(FILE_RDATA, 2) == 8'hff)) else $error("inc skip");
   br_low_a: assert property (br |=> PC[10:0] == $past(INSTR[10:0]))
      else $error("branch low");
   br_high_a: assert property (br |=> PC[12:11] == $past(PC_HIGH_LATCH[4:3]))
      else $error("branch high");
   or_w_a: assert property (lo |=> W_REG == ($past(W_REG) | $past(INSTR[7:0])))
      else $error("or result");
   or_zero_a: assert property (lo |=> Z_FLAG == (W_REG == 8'h00))
      else $error("zero flag");
   cover property (SKIPPED);
   cover property (FILE_WE);
   cover property (br);
endmodule
bind sble_exec sble_chk u_chk (.*);

// ---- verification/sble_exec_tb.sv ----
// Self-checking bench for sble_exec with a file register model.
// Assumes the defs header is on the include path.
`timescale 1ns/1ns
`include "sble_defs.svh"
module sble_exec_tb;
   logic        CLOCK, RST_N, INSTR_VALID, INSTR_READY, FILE_WE, Z_FLAG, SKIPPED;
   logic [13:0] INSTR;
   logic [7:0]  FILE_RDATA, PC_HIGH_LATCH, FILE_WDATA, W_REG;
   logic [6:0]  FILE_ADDR;
   logic [12:0] PC;
   int          error_cnt = 0, checked = 0;
   sble_exec u_dut (.*);
   sble_fmem u_mem (.clk(CLOCK), .addr(FILE_ADDR), .we(FILE_WE), .wdata(FILE_WDATA),
      .rdata(FILE_RDATA));
   initial begin
      CLOCK = 0;
      forever #25 CLOCK = ~CLOCK;
   end
   task automatic chk(input string n, input logic [12:0] e, input logic [12:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("FAIL %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic conclude;
      if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Offers one word at a falling edge; valid stays up between words
   task automatic op(input logic [13:0] i);
      while (INSTR_READY !== 1'b1) @(negedge CLOCK);
      INSTR_VALID = 1;
      INSTR = i;
      @(negedge CLOCK);
   endtask
   task automatic t_or;
      op({`SBLE_OP_LIT_OR, 8'h00});
      chk("z set", 1, Z_FLAG);
      op({`SBLE_OP_LIT_OR, 8'h5a});
      op({`SBLE_OP_LIT_OR, 8'h81});
      chk("w or", 8'hdb, W_REG);
      chk("z clear", 0, Z_FLAG);
   endtask
   task automatic t_dec;
      u_mem.mem[5] = 8'h02;
      op({`SBLE_OP_DEC_SKIP, 8'h85});
      op(14'h0000);
      chk("no skip", 0, SKIPPED);
      chk("dec file", 8'h01, u_mem.mem[5]);
      op({`SBLE_OP_DEC_SKIP, 8'h05});
      op(14'h0000);
      chk("skip", 1, SKIPPED);
      chk("dec w", 8'h00, W_REG);
      chk("z kept", 0, Z_FLAG);
   endtask
   task automatic t_inc;
      u_mem.mem[9] = 8'hff;
      op({`SBLE_OP_LIT_OR, 8'h00});
      op({`SBLE_OP_INC_SKIP, 8'h89});
      op(14'h0000);
      chk("skip", 1, SKIPPED);
      chk("inc file", 8'h00, u_mem.mem[9]);
      chk("z kept", 1, Z_FLAG);
      op({`SBLE_OP_INC_SKIP, 8'h09});
      op(14'h0000);
      chk("no skip", 0, SKIPPED);
      chk("inc w", 8'h01, W_REG);
   endtask
   task automatic t_br;
      PC_HIGH_LATCH = 8'h08;
      op({`SBLE_OP_BRANCH, 11'h7ff});
      chk("pc", 13'h0fff, PC);
      op(14'h0000);
      chk("slot", 1, SKIPPED);
      chk("pc slot", 13'h1000, PC);
      PC_HIGH_LATCH = 8'he7;
      op({`SBLE_OP_BRANCH, 11'h000});
      chk("pc high", 13'h0000, PC);
   endtask
   initial begin
      RST_N = 0;
      INSTR_VALID = 0;
      INSTR = 0;
      PC_HIGH_LATCH = 0;
      repeat (5) @(negedge CLOCK);
      RST_N = 1;
      repeat (3) @(negedge CLOCK);
      t_or;
      t_dec;
      t_inc;
      t_br;
      conclude;
   end
   initial begin
      #20000;
      error_cnt++;
      conclude;
   end
endmodule

// ---- verification/sble_fmem.sv ----
// File register model for the executor's far side.
// Assumes the block registers the address before reads.
`timescale 1ns/1ns
module sble_fmem (
   input  wire logic       clk,
   input  wire logic [6:0] addr,
   input  wire logic       we,
   input  wire logic [7:0] wdata,
   output logic      [7:0] rdata
);
   logic [7:0] mem [128];
   assign rdata = mem[addr];
   always @(posedge clk) if (we) mem[addr] <= wdata;
endmodule
